// ### logic/erbm_cfg.svh
// Purpose: constants of the receive buffer descriptor manager
// Assumes: included by its bare name
// Notes:   offsets are byte addresses on the plain register port
`ifndef ERBM_CFG_SVH
`define ERBM_CFG_SVH
`define ERBM_REG_CFG      8'h00
`define ERBM_REG_CTRL     8'h04
`define ERBM_REG_QPTR     8'h08
`define ERBM_REG_STAT     8'h0C
`define ERBM_CFG_JUMBO    3
`define ERBM_CFG_OFF_LO   14
`define ERBM_CFG_STRIP    17
`define ERBM_CTRL_RXEN    2
`define ERBM_STAT_BNA     0
`define ERBM_STAT_BUSY    1
`define ERBM_CFG_RST      32'h0000_0000
`define ERBM_BUF_BYTES    8'h80
`define ERBM_LIST_MAX     1024
`endif

// ### logic/erbm_pkg.sv
// Purpose: types of the receive buffer descriptor manager
// Assumes: nothing
// Notes:   frame info is sampled with the last byte
package erbm_pkg;
    typedef enum logic [2:0] {
        ERBM_IDLE, ERBM_FETCH, ERBM_DROP, ERBM_FILL,
        ERBM_WDATA, ERBM_WSTAT, ERBM_WOWN
    } erbm_state_e;
    typedef struct packed {
        logic [7:0] data;
        logic       last;
        logic       fcs;
    } erbm_rx_byte_s;
    typedef struct packed {
        logic       bcast;
        logic       mcast;
        logic       ucast;
        logic       ext;
        logic [3:0] spec;
        logic       type_id;
        logic       vlan;
        logic       prio;
        logic [2:0] vlan_pri;
        logic       cfi;
    } erbm_frm_info_s;
    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } erbm_mem_req_s;
endpackage : erbm_pkg

// ### logic/erbm_rx_buf_mgr.sv
// Purpose: receive buffer descriptor manager of the ethernet_media_access_unit DMA
// Assumes: memory answers each request with a one-cycle mem_ack
// Notes:   one byte taken every second cycle at most
//
// The placing of the registers and the address-and-strobe port were decided locally.
`include "erbm_cfg.svh"
module erbm_rx_buf_mgr #(
    parameter int LIST_MAX = `ERBM_LIST_MAX
) (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    srst,
    // Register port
    input  wire logic [7:0]              reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [31:0]                  reg_rdata_ff,
    // Frame byte stream
    input  wire logic                    rx_valid,
    input  erbm_pkg::erbm_rx_byte_s      rx_byte,
    input  erbm_pkg::erbm_frm_info_s     frm_info,
    output logic                         rx_ready_ff,
    // Memory master
    output erbm_pkg::erbm_mem_req_s      mem_ff,
    input  wire logic                    mem_ack,
    input  wire logic [31:0]             mem_rdata,
    // Event
    output logic                         bna_pulse_ff
);
    import erbm_pkg::*;

    if (LIST_MAX < 1 || LIST_MAX > `ERBM_LIST_MAX) begin : g_chk
        $error("LIST_MAX out of range");
    end

    localparam logic [9:0] IDX_LAST = 10'(LIST_MAX - 1);

    // Status word of one descriptor
    function automatic logic [31:0] stat_word(
        input logic           eof,
        input logic           sof,
        input logic           jumbo,
        input logic [1:0]     off,
        input logic [13:0]    len,
        input erbm_frm_info_s fi
    );
        logic [31:0] w;
        w     = 32'h0000_0000;
        w[14] = sof;
        w[13:12] = jumbo ? 2'b00 : off;
        if (eof) begin
            w[31]    = fi.bcast;
            w[30]    = fi.mcast;
            w[29]    = fi.ucast;
            w[28]    = fi.ext;
            w[26:23] = fi.spec;
            w[22]    = fi.type_id;
            w[21]    = fi.vlan;
            w[20]    = fi.vlan & fi.prio;
            w[19:17] = fi.vlan ? fi.vlan_pri : 3'b000;
            w[16]    = fi.vlan & fi.cfi;
            w[15]    = 1'b1;
            w[11:0]  = len[11:0];
            if (jumbo) begin
                w[13:12] = len[13:12];
            end
        end
        return w;
    endfunction : stat_word

    // Registers
    erbm_state_e    state_ff,   nxt_state;
    logic [31:0]    cfg_ff,     nxt_cfg;
    logic           rxen_ff,    nxt_rxen;
    logic [31:0]    qbase_ff,   nxt_qbase;
    logic [9:0]     idx_ff,     nxt_idx;
    logic           bna_ff,     nxt_bna;
    logic [29:0]    buf_ff,     nxt_buf;
    logic           wrap_ff,    nxt_wrap;
    logic [7:0]     pos_ff,     nxt_pos;
    logic [4:0]     widx_ff,    nxt_widx;
    logic [31:0]    word_ff,    nxt_word;
    logic [3:0]     be_ff,      nxt_be;
    logic [13:0]    len_ff,     nxt_len;
    logic           sof_ff,     nxt_sof;
    logic           eof_ff,     nxt_eof;
    logic           full_ff,    nxt_full;
    erbm_frm_info_s fi_ff,      nxt_fi;
    erbm_mem_req_s  nxt_mem;
    logic           nxt_ready;
    logic [31:0]    nxt_rdata;
    logic           nxt_bpulse;

    // Decode and datapath
    wire        wr_cfg   = reg_wr & (reg_addr == `ERBM_REG_CFG);
    wire        wr_ctrl  = reg_wr & (reg_addr == `ERBM_REG_CTRL);
    wire        wr_qptr  = reg_wr & (reg_addr == `ERBM_REG_QPTR);
    wire        wr_stat  = reg_wr & (reg_addr == `ERBM_REG_STAT);
    wire [1:0]  off_cfg  = cfg_ff[`ERBM_CFG_OFF_LO+1:`ERBM_CFG_OFF_LO];
    wire        jumbo    = cfg_ff[`ERBM_CFG_JUMBO];
    wire        strip    = cfg_ff[`ERBM_CFG_STRIP];
    wire [31:0] qptr     = qbase_ff + {19'h0_0000, idx_ff, 3'b000};
    wire        take     = rx_valid & rx_ready_ff;
    wire        store    = ~(strip & rx_byte.fcs);
    wire [1:0]  lane     = pos_ff[1:0];
    wire [7:0]  pos_inc  = pos_ff + {7'h00, store};
    wire        at_end   = pos_inc == `ERBM_BUF_BYTES;
    wire        wrd_done = store & (lane == 2'b11);
    wire        flush    = wrd_done | rx_byte.last | at_end;
    wire [31:0] buf_addr = {buf_ff, 2'b00};
    wire [31:0] dat_addr = buf_addr + {25'h000_0000, widx_ff, 2'b00};
    wire        own_bit  = mem_rdata[0];
    wire [9:0]  idx_next = (wrap_ff | idx_ff == IDX_LAST) ? 10'h000
                                                           : idx_ff + 10'h001;
    wire [31:0] st_word  = stat_word(eof_ff, sof_ff, jumbo, off_cfg, len_ff, fi_ff);
    wire [31:0] stat_rd  = {30'h0000_0000, state_ff != ERBM_IDLE, bna_ff};

    always_comb begin
        nxt_state  = state_ff;
        nxt_cfg    = wr_cfg ? reg_wdata : cfg_ff;
        nxt_rxen   = wr_ctrl ? reg_wdata[`ERBM_CTRL_RXEN] : rxen_ff;
        nxt_qbase  = wr_qptr ? {reg_wdata[31:2], 2'b00} : qbase_ff;
        nxt_idx    = wr_qptr ? 10'h000 : idx_ff;
        nxt_bna    = bna_ff & ~(wr_stat & reg_wdata[`ERBM_STAT_BNA]);
        nxt_bpulse = 1'b0;
        nxt_buf    = buf_ff;
        nxt_wrap   = wrap_ff;
        nxt_pos    = pos_ff;
        nxt_widx   = widx_ff;
        nxt_word   = word_ff;
        nxt_be     = be_ff;
        nxt_len    = len_ff;
        nxt_sof    = sof_ff;
        nxt_eof    = eof_ff;
        nxt_full   = full_ff;
        nxt_fi     = fi_ff;
        nxt_mem    = mem_ff;
        nxt_ready  = 1'b0;
        nxt_rdata  = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `ERBM_REG_CFG:  nxt_rdata = cfg_ff;
                `ERBM_REG_CTRL: nxt_rdata = {29'h0000_0000, rxen_ff, 2'b00};
                `ERBM_REG_QPTR: nxt_rdata = qptr;
                `ERBM_REG_STAT: nxt_rdata = stat_rd;
                default:        nxt_rdata = 32'h0000_0000;
            endcase
        end
        if (mem_ff.req & mem_ack) begin
            nxt_mem.req = 1'b0;
        end
        case (state_ff)
            ERBM_IDLE: begin
                if (rx_valid & rxen_ff) begin
                    nxt_sof   = 1'b1;
                    nxt_len   = 14'h0000;
                    nxt_state = ERBM_FETCH;
                end
            end
            ERBM_FETCH: begin
                if (!mem_ff.req) begin
                    nxt_mem = '{req: 1'b1, we: 1'b0, addr: qptr,
                                wdata: 32'h0000_0000, be: 4'hF};
                end else if (mem_ack) begin
                    nxt_buf  = mem_rdata[31:2];
                    nxt_wrap = mem_rdata[1];
                    nxt_pos  = sof_ff ? {6'h00, off_cfg} : 8'h00;
                    nxt_be   = 4'h0;
                    nxt_word = 32'h0000_0000;
                    if (own_bit) begin
                        // Shared flag: hardware set beats software clear
                        nxt_bna    = 1'b1;
                        nxt_bpulse = 1'b1;
                        nxt_state  = ERBM_DROP;
                    end else begin
                        nxt_ready = 1'b1;
                        nxt_state = ERBM_FILL;
                    end
                end
            end
            ERBM_DROP: begin
                // Frame discarded; earlier buffers stay used
                // Same one-cycle gap after a take as in FILL
                nxt_ready = ~take;
                if (take & rx_byte.last) begin
                    nxt_state = ERBM_IDLE;
                end
            end
            ERBM_FILL: begin
                nxt_ready = ~take;
                if (take) begin
                    if (store) begin
                        nxt_word[lane*8 +: 8] = rx_byte.data;
                        nxt_be[lane]          = 1'b1;
                        nxt_len               = len_ff + 14'h0001;
                    end
                    nxt_widx = pos_ff[6:2];
                    nxt_pos  = pos_inc;
                    nxt_eof  = rx_byte.last;
                    nxt_full = ~rx_byte.last & at_end;
                    if (rx_byte.last) begin
                        nxt_fi = frm_info;
                    end
                    if (flush) begin
                        nxt_ready = 1'b0;
                        nxt_state = ERBM_WDATA;
                    end
                end
            end
            ERBM_WDATA: begin
                if (be_ff == 4'h0) begin
                    // Stripped FCS may leave an empty word
                    nxt_state = (eof_ff | full_ff) ? ERBM_WSTAT : ERBM_FILL;
                    nxt_ready = ~(eof_ff | full_ff);
                end else if (!mem_ff.req) begin
                    nxt_mem = '{req: 1'b1, we: 1'b1, addr: dat_addr,
                                wdata: word_ff, be: be_ff};
                end else if (mem_ack) begin
                    nxt_be    = 4'h0;
                    nxt_word  = 32'h0000_0000;
                    nxt_state = (eof_ff | full_ff) ? ERBM_WSTAT : ERBM_FILL;
                    nxt_ready = ~(eof_ff | full_ff);
                end
            end
            ERBM_WSTAT: begin
                // Status first, so a used bit never shows stale status
                if (!mem_ff.req) begin
                    nxt_mem = '{req: 1'b1, we: 1'b1, addr: qptr + 32'h0000_0004,
                                wdata: st_word, be: 4'hF};
                end else if (mem_ack) begin
                    nxt_state = ERBM_WOWN;
                end
            end
            ERBM_WOWN: begin
                if (!mem_ff.req) begin
                    nxt_mem = '{req: 1'b1, we: 1'b1, addr: qptr,
                                wdata: {buf_ff, wrap_ff, 1'b1}, be: 4'hF};
                end else if (mem_ack) begin
                    nxt_idx   = idx_next;
                    nxt_sof   = 1'b0;
                    nxt_state = eof_ff ? ERBM_IDLE : ERBM_FETCH;
                end
            end
            default: begin
                nxt_state = ERBM_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff     <= ERBM_IDLE;
            cfg_ff       <= `ERBM_CFG_RST;
            rxen_ff      <= 1'b0;
            qbase_ff     <= 32'h0000_0000;
            idx_ff       <= 10'h000;
            bna_ff       <= 1'b0;
            bna_pulse_ff <= 1'b0;
            buf_ff       <= 30'h0000_0000;
            wrap_ff      <= 1'b0;
            pos_ff       <= 8'h00;
            widx_ff      <= 5'h00;
            word_ff      <= 32'h0000_0000;
            be_ff        <= 4'h0;
            len_ff       <= 14'h0000;
            sof_ff       <= 1'b0;
            eof_ff       <= 1'b0;
            full_ff      <= 1'b0;
            fi_ff        <= '0;
            mem_ff       <= '0;
            rx_ready_ff  <= 1'b0;
            reg_rdata_ff <= 32'h0000_0000;
        end else begin
            state_ff     <= nxt_state;
            cfg_ff       <= nxt_cfg;
            rxen_ff      <= nxt_rxen;
            qbase_ff     <= nxt_qbase;
            idx_ff       <= nxt_idx;
            bna_ff       <= nxt_bna;
            bna_pulse_ff <= nxt_bpulse;
            buf_ff       <= nxt_buf;
            wrap_ff      <= nxt_wrap;
            pos_ff       <= nxt_pos;
            widx_ff      <= nxt_widx;
            word_ff      <= nxt_word;
            be_ff        <= nxt_be;
            len_ff       <= nxt_len;
            sof_ff       <= nxt_sof;
            eof_ff       <= nxt_eof;
            full_ff      <= nxt_full;
            fi_ff        <= nxt_fi;
            mem_ff       <= nxt_mem;
            rx_ready_ff  <= nxt_ready;
            reg_rdata_ff <= nxt_rdata;
        end
    end
endmodule : erbm_rx_buf_mgr

// ### verif/erbm_mem_model.sv
// Purpose: word memory in the place of system memory
// Assumes: one request at a time, held until mem_ack
// Notes:   idle read data is inverted so stale words never match
module erbm_mem_model
    import erbm_pkg::*;
(
    // Clock, reset, pacing
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [1:0]  lag,
    // Memory slave
    input  erbm_mem_req_s    mem_req,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem_arr [0:1023];
    logic [1:0]  wait_ff;
    logic [31:0] last_ff;
    assign mem_ack   = mem_req.req && (wait_ff >= lag);
    assign mem_rdata = mem_ack ? mem_arr[mem_req.addr[11:2]] : ~last_ff;
    // Plain always: the bench also writes the array as software
    always @(posedge ref_clk) begin
        if (srst) begin
            wait_ff <= 2'h0;
            last_ff <= 32'h0000_0000;
        end else if (mem_ack) begin
            wait_ff <= 2'h0;
            last_ff <= mem_rdata;
            for (int i = 0; i < 4; i++) begin
                if (mem_req.we && mem_req.be[i]) begin
                    mem_arr[mem_req.addr[11:2]][8*i +: 8] <= mem_req.wdata[8*i +: 8];
                end
            end
        end else if (mem_req.req) begin
            wait_ff <= wait_ff + 2'h1;
        end
    end
endmodule : erbm_mem_model

// ### verif/erbm_rx_buf_mgr_sva.sv
// Purpose: port checks of the receive buffer descriptor manager
// Assumes: single clock domain
// Notes:   bound to every instance
module erbm_rx_buf_mgr_sva
    import erbm_pkg::*;
#(
    parameter int LIST_MAX = 1024
) (
    input wire logic     ref_clk,
    input wire logic     srst,
    input wire logic [7:0] reg_addr,
    input wire logic     reg_rd,
    input wire logic [31:0] reg_rdata_ff,
    input wire logic     rx_valid,
    input wire logic     rx_ready_ff,
    input erbm_mem_req_s mem_ff,
    input wire logic     mem_ack,
    input wire logic     bna_pulse_ff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0000_0000)
        else $error("read data outside read answer");
    a_unmapped_rd: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata_ff == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_qptr_align: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata_ff[1:0] == 2'h0)
        else $error("queue pointer not word aligned");
    a_mem_align: assert property (mem_ff.req |-> mem_ff.addr[1:0] == 2'h0)
        else $error("memory address not word aligned");
    a_req_held: assert property (mem_ff.req && !mem_ack |=> mem_ff.req && $stable(mem_ff))
        else $error("memory request changed before ack");
    a_take_gap: assert property (rx_valid && rx_ready_ff |=> !rx_ready_ff)
        else $error("ready high right after a take");
    a_bna_pulse: assert property ($rose(bna_pulse_ff) |=> !bna_pulse_ff)
        else $error("buffer not available pulse too long");
    a_ready_quiet: assert property (rx_ready_ff |-> !mem_ff.req)
        else $error("byte offered while memory busy");
endmodule : erbm_rx_buf_mgr_sva

bind erbm_rx_buf_mgr erbm_rx_buf_mgr_sva #(.LIST_MAX(LIST_MAX)) u_sva (.ref_clk(ref_clk),
    .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .rx_valid(rx_valid), .rx_ready_ff(rx_ready_ff), .mem_ff(mem_ff), .mem_ack(mem_ack),
    .bna_pulse_ff(bna_pulse_ff));

// ### verif/tb_top.sv
// Purpose: self-checking bench of the receive buffer descriptor manager
// Assumes: list shortened to three entries
// Notes:   memory image compared word by word after each frame
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import erbm_pkg::*;
    localparam int LMAX = 3;
    localparam logic [31:0] QB = 32'h0000_0100;
    localparam logic [31:0] BB = 32'h0000_0400;
    logic           ref_clk = 1'b0;
    logic           srst = 1'b1;
    logic [7:0]     reg_addr = 8'h00;
    logic [31:0]    reg_wdata = 32'h0000_0000;
    logic           reg_wr = 1'b0;
    logic           reg_rd = 1'b0;
    logic           rx_valid = 1'b0;
    erbm_rx_byte_s  rx_byte = '0;
    erbm_frm_info_s frm_info = '0;
    logic [1:0]     lag = 2'h0;
    logic [31:0]    reg_rdata_ff, mem_rdata, rv, w0;
    logic           rx_ready_ff, mem_ack, bna_pulse_ff, sof;
    erbm_mem_req_s  mem_ff;
    logic [31:0]    seed = 32'h0000_0040;
    logic [31:0]    exp_mem [0:1023];
    int             fail_count = 0;
    int             checked = 0;
    int             idx = 0;
    int             bna_n = 0;
    int             b, cap;
    int             ln [4] = '{64, 204, 304, 125};
    logic [1:0]     os [4] = '{2'h0, 2'h3, 2'h2, 2'h3};
    logic [3:0]     sp = 4'h2;
    logic [3:0]     jb = 4'h4;

    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (bna_pulse_ff === 1'b1) bna_n++;

    erbm_rx_buf_mgr #(.LIST_MAX(LMAX)) DUT (.ref_clk(ref_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(reg_rdata_ff), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .frm_info(frm_info), .rx_ready_ff(rx_ready_ff), .mem_ff(mem_ff),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .bna_pulse_ff(bna_pulse_ff));
    erbm_mem_model MEM (.ref_clk(ref_clk), .srst(srst), .lag(lag), .mem_req(mem_ff),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic rwr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : rwr

    task automatic rrd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        // Answer stands only in this cycle; sample it once it has settled
        #1;
        d = reg_rdata_ff;
    endtask : rrd

    task automatic setw(input int w, input logic [31:0] v);
        MEM.mem_arr[w] = v;
        exp_mem[w] = v;
    endtask : setw

    task automatic clr_own();
        for (int i = 0; i < 4; i++) setw(QB/4 + 2*i, exp_mem[QB/4 + 2*i] & 32'hFFFF_FFFE);
    endtask : clr_own

    // Closes the current buffer in the model and moves to the next entry
    task automatic shut(input logic [31:0] stat);
        exp_mem[QB/4 + 2*idx + 1] = stat;
        exp_mem[QB/4 + 2*idx] = w0 | 32'h0000_0001;
        idx = (w0[1] || idx == LMAX - 1) ? 0 : idx + 1;
        w0 = exp_mem[QB/4 + 2*idx];
        b = 0;
        cap = 128;
        sof = 1'b0;
    endtask : shut

    task automatic frame(input int n, input logic [1:0] off, input logic strip, input logic jmb);
        int st, bn;
        logic own, f;
        logic [31:0] ad, s2;
        erbm_frm_info_s fi;
        rv = xs();
        fi = rv[14:0];
        lag <= rv[17:16];
        rwr(8'h00, {14'h0, strip, 1'h0, off, 10'h0, jmb, 3'h0});
        st = n - (strip ? 4 : 0);
        bn = bna_n;
        w0 = exp_mem[QB/4 + 2*idx];
        own = w0[0];
        b = 0;
        cap = 128 - off;
        sof = 1'b1;
        for (int k = 0; k < n; k++) begin
            rv = xs();
            f = (k >= n - 4);
            rx_valid <= 1'b1;
            rx_byte <= {rv[7:0], k == n - 1, f};
            frm_info <= fi;
            if (!own && !(strip && f)) begin
                if (b == cap) shut({16'h0, 1'h0, sof, jmb ? 2'h0 : off, 12'h0});
                ad = {w0[31:2], 2'h0} + (sof ? off : 2'h0) + b;
                exp_mem[ad >> 2][8*ad[1:0] +: 8] = rv[7:0];
                b++;
            end
            for (int t = 0; t < 500; t++) begin
                @(posedge ref_clk);
                if (rx_ready_ff === 1'b1) break;
            end
        end
        rx_valid <= 1'b0;
        if (!own) begin
            s2 = {fi[14:11], 1'h0, fi[10:0], 1'h1, sof, jmb ? st[13:12] : off, st[11:0]};
            if (!fi.vlan) s2[20:16] = 5'h0;
            shut(s2);
        end
        for (int t = 0; t < 200; t++) begin
            rrd(8'h0C, rv);
            if (rv[1] === 1'b0) break;
        end
        for (int w = 'h40; w < 'h180; w++) chk("mem", exp_mem[w], MEM.mem_arr[w]);
        chk("bna", own, bna_n - bn);
        if (!own) begin
            rrd(8'h08, rv);
            chk("qptr", QB + 8*idx, rv);
        end
    endtask : frame

    initial begin
        #300000;
        fail_count++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        rrd(8'h00, rv);
        chk("cfg_reset", 32'h0000_0000, rv);
        rrd(8'h10, rv);
        chk("unmapped", 32'h0000_0000, rv);
        for (int w = 0; w < 1024; w++) setw(w, xs());
        for (int i = 0; i < 4; i++) setw(QB/4 + 2*i, BB + 128*i);
        rwr(8'h08, QB);
        rwr(8'h04, 32'h0000_0004);
        for (int i = 0; i < 4; i++) begin
            frame(ln[i], os[i], sp[i], jb[i]);
            if (i < 3) clr_own();
        end
        // Entry zero still owned: whole frame must be dropped
        rwr(8'h08, QB);
        idx = 0;
        frame(60, 2'h1, 1'h0, 1'h0);
        rrd(8'h0C, rv);
        chk("bna_flag", 32'h0000_0001, rv & 32'h0000_0001);
        rwr(8'h0C, 32'h0000_0001);
        rrd(8'h0C, rv);
        chk("bna_clear", 32'h0000_0000, rv & 32'h0000_0001);
        clr_own();
        setw(QB/4, exp_mem[QB/4] | 32'h0000_0002);
        rwr(8'h08, QB);
        idx = 0;
        frame(64, 2'h2, 1'h1, 1'h0);
        clr_own();
        frame(100, 2'h1, 1'h0, 1'h1);
        final_report();
    end
endmodule : tb_top
